// *** verilog/fsp_pkg.sv ***
/*
 * Constants shared by the sector-protected program memory controller and
 * its serial programming link receiver: link frame layout, command codes,
 * sector geometry, access-guard keys and the option byte layout.
 * Assumes a 64 Kbyte address space with the array at its top end.
 */
// How it works
// - Erase whole array or one sector; program one byte at a time.
// - Sector erase or program never touches bytes of other sectors.
// - Programming tool socket or in-circuit mode may alter all sectors and options.
// - Application mode may alter every sector but sector zero.
// - 4K array has sector zero, 8K adds one, larger adds two.
// - Sectors zero and one are 4K at the top; zero is F000h-FFFFh.
// - Protection blocks external read-out and any write to the array.
// - Removing protection first erases the whole array automatically.
// - One option byte bit turns read-out protection on and off.
// - Link is tool clock, two-way data, select pin and reset pin; the link here uses no reset pin, select low clears it.
// - With the tool attached, link clock and data pins are not for application.
// - Key sequence must arm each application program or erase request.

package fsp_pkg;

	// ==================================================================
	// array geometry
	localparam int ADDR_SPACE = 65536;
	localparam int SECTOR_BYTES = 4096;
	localparam logic [15:0] SECTOR0_BASE = 16'hF000;
	localparam logic [15:0] SECTOR1_BASE = 16'hE000;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ==================================================================
	// option byte: bit low means read-out protection active
	localparam int OPT_PROTECT_BIT = 0;

	// ==================================================================
	// operation codes, shared by the application port and the link, except read, which only the link accepts
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h03;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h04;
	localparam logic [7:0] CMD_OPTION_WRITE = 8'h05;

	// ==================================================================
	// access guard keys, written in this order
	localparam logic [7:0] GUARD_KEY1 = 8'h56;
	localparam logic [7:0] GUARD_KEY2 = 8'hAE;

	// ==================================================================
	// link frame: 32 bits in msb first, then read byte out
	localparam int LINK_WORD_BITS = 32;
	localparam logic [5:0] LINK_LAST_IN = 6'h1F;
	localparam logic [5:0] LINK_LOAD_OUT = 6'h27;
	localparam logic [5:0] LINK_LAST_OUT = 6'h2F;
	localparam logic [5:0] LINK_CNT_MAX = 6'h30;

	// ==================================================================
	// controller states, one-hot
	typedef enum logic [2:0] {
		FSP_IDLE = 3'b001,
		FSP_ERASE = 3'b010,
		FSP_OPTION = 3'b100
	} fsp_state_t;

endpackage : fsp_pkg

// *** verilog/fsp_link.sv ***
/*
 * Serial programming link receiver, clocked by the tool's link clock.
 * Assumes the link clock runs only while the select pin is high, and that
 * the tool keeps the frame open for 48 clocks on reads, 40 otherwise.
 */
`timescale 1ns/1ps

module fsp_link (
	// link pins
	input wire logic link_clk,
	input wire logic prog_voltage_select_pin,
	input wire logic prog_link_data_in,
	output logic prog_link_data_out,
	output logic prog_link_data_oe_n,
	// toward the controller domain
	output logic link_req,
	output logic [31:0] link_word,
	input wire logic link_ack,
	input wire logic [7:0] link_rd_byte
);

	logic [5:0] bit_cnt;
	logic [31:0] shift_in;
	logic [7:0] shift_out;
	logic ack_s1;
	logic ack_s2;
	logic is_read;

	// ==================================================================
	// frame decode
	assign is_read = (link_word[31:24] == fsp_pkg::CMD_READ);

	// ==================================================================
	// frame engine, cleared whenever the select pin drops
	// select pin frames
	always_ff @(posedge link_clk or negedge prog_voltage_select_pin) begin
		if (!prog_voltage_select_pin) begin
			bit_cnt <= 6'h00;
			shift_in <= 32'h0000_0000;
			shift_out <= 8'hFF;
			link_req <= 1'b0;
			link_word <= 32'h0000_0000;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			prog_link_data_out <= 1'b1;
			prog_link_data_oe_n <= 1'b1;
		end else begin
			ack_s1 <= link_ack;
			ack_s2 <= ack_s1;
			if (bit_cnt != fsp_pkg::LINK_CNT_MAX) begin
				bit_cnt <= bit_cnt + 6'h01;
			end
			if (bit_cnt <= fsp_pkg::LINK_LAST_IN) begin
				shift_in <= {shift_in[30:0], prog_link_data_in};
			end
			// whole word held stable for the controller
			if (bit_cnt == fsp_pkg::LINK_LAST_IN) begin
				link_word <= {shift_in[30:0], prog_link_data_in};
				link_req <= 1'b1;
			end
			// read byte driven on the next eight clocks
			if (bit_cnt == fsp_pkg::LINK_LOAD_OUT && is_read) begin
				shift_out <= ack_s2 ? {link_rd_byte[6:0], 1'b1} : 8'hFF;
				prog_link_data_out <= ack_s2 ? link_rd_byte[7] : 1'b1;
				prog_link_data_oe_n <= 1'b0;
			end else if (bit_cnt > fsp_pkg::LINK_LOAD_OUT && bit_cnt <= fsp_pkg::LINK_LAST_OUT) begin
				prog_link_data_out <= shift_out[7];
				shift_out <= {shift_out[6:0], 1'b1};
			end else begin
				prog_link_data_oe_n <= 1'b1;
				prog_link_data_out <= 1'b1;
			end
		end
	end

endmodule : fsp_link

// *** verilog/fsp_flash_ctrl.sv ***
/*
 * Sector-protected program memory controller: byte array at the top of
 * the address space, byte programming, sector and whole-array erase,
 * per-mode sector protection, read-out protection with automatic erase on
 * removal, and an access guard for application requests.
 * Assumes the application port is on clk; link pins come from the tool.
 */
`timescale 1ns/1ps

module fsp_flash_ctrl #(
	parameter int FLASH_SIZE = 16384
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// application port
	input wire logic app_req,
	input wire logic [7:0] app_cmd,
	input wire logic [15:0] app_addr,
	input wire logic [7:0] app_wdata,
	input wire logic guard_key_valid,
	input wire logic [7:0] guard_key,
	input wire logic [15:0] app_rd_addr,
	output logic [7:0] app_rdata,
	// status
	output logic busy,
	output logic op_done,
	output logic op_rejected,
	output logic readout_protect_active,
	output logic in_circuit_comm_mode,
	output logic app_pins_available,
	// tool pins
	input wire logic tool_socket_pin,
	input wire logic tool_attached_pin,
	input wire logic link_clk,
	input wire logic prog_voltage_select_pin,
	input wire logic prog_link_data_in,
	output logic prog_link_data_out,
	output logic prog_link_data_oe_n
);

	localparam int IW = $clog2(FLASH_SIZE + 1);
	localparam logic [15:0] ARRAY_BASE = 16'(fsp_pkg::ADDR_SPACE - FLASH_SIZE);
	localparam logic [IW-1:0] OPT_IDX = IW'(FLASH_SIZE);
	localparam logic [IW-1:0] LAST_IDX = IW'(FLASH_SIZE - 1);
	localparam logic [IW-1:0] SEC_IDX = IW'(fsp_pkg::SECTOR_BYTES);

	// ==================================================================
	// storage: array bytes plus the option byte after them
	logic [7:0] mem [0:FLASH_SIZE];

	initial begin
		for (int i = 0; i <= FLASH_SIZE; i++) begin
			mem[i] = fsp_pkg::ERASED_BYTE;
		end
	end

	// ==================================================================
	// helpers
	function automatic logic in_array(input logic [15:0] a);
		in_array = (a >= ARRAY_BASE);
	endfunction : in_array

	function automatic logic [IW-1:0] to_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - ARRAY_BASE;
		to_idx = d[IW-1:0];
	endfunction : to_idx

	// sector number from address; 8K and below have no sector two
	function automatic logic [1:0] sector_of(input logic [15:0] a);
		if (a >= fsp_pkg::SECTOR0_BASE) begin
			sector_of = 2'd0;
		end else if (a >= fsp_pkg::SECTOR1_BASE) begin
			sector_of = 2'd1;
		end else begin
			sector_of = 2'd2;
		end
	endfunction : sector_of

	// ==================================================================
	// pin synchronisers and link handshake
	logic sel_s1, sel_s2;
	logic att_s1, att_s2;
	logic sock_s1, sock_s2;
	logic lreq_s1, lreq_s2, lreq_d;
	logic link_req;
	logic [31:0] link_word;
	logic link_ack;
	logic [7:0] link_rd_byte;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
			att_s1 <= 1'b0;
			att_s2 <= 1'b0;
			sock_s1 <= 1'b0;
			sock_s2 <= 1'b0;
			lreq_s1 <= 1'b0;
			lreq_s2 <= 1'b0;
			lreq_d <= 1'b0;
		end else begin
			sel_s1 <= prog_voltage_select_pin;
			sel_s2 <= sel_s1;
			att_s1 <= tool_attached_pin;
			att_s2 <= att_s1;
			sock_s1 <= tool_socket_pin;
			sock_s2 <= sock_s1;
			lreq_s1 <= link_req;
			lreq_s2 <= lreq_s1;
			lreq_d <= lreq_s2;
		end
	end

	fsp_link u_link (
		.link_clk(link_clk),
		.prog_voltage_select_pin(prog_voltage_select_pin),
		.prog_link_data_in(prog_link_data_in),
		.prog_link_data_out(prog_link_data_out),
		.prog_link_data_oe_n(prog_link_data_oe_n),
		.link_req(link_req),
		.link_word(link_word),
		.link_ack(link_ack),
		.link_rd_byte(link_rd_byte)
	);

	// ==================================================================
	// request selection: a new link word beats the application port
	fsp_pkg::fsp_state_t state;
	logic [1:0] guard_stage;
	logic guard_armed;
	logic link_new;
	logic req_valid;
	logic req_link;
	logic [7:0] req_cmd;
	logic [15:0] req_addr;
	logic [7:0] req_data;
	logic full_access;
	logic [1:0] req_sector;
	logic sector_exists;
	logic sector_ok;
	logic idle;
	logic do_program;
	logic do_sector_erase;
	logic do_mass_erase;
	logic do_option;
	logic do_unprotect;
	logic do_read;
	logic app_blocked;

	assign idle = (state == fsp_pkg::FSP_IDLE);
	assign link_new = lreq_s2 & ~lreq_d & sel_s2;
	assign guard_armed = (guard_stage == 2'd2);
	assign app_blocked = app_req & ~link_new & ~guard_armed;
	assign req_link = link_new;
	assign req_valid = link_new | (app_req & guard_armed);
	assign req_cmd = req_link ? link_word[31:24] : app_cmd;
	assign req_addr = req_link ? link_word[23:8] : app_addr;
	assign req_data = req_link ? link_word[7:0] : app_wdata;
	// socket or link mode opens all
	assign full_access = req_link | sock_s2;
	assign req_sector = sector_of(req_addr);
	assign sector_exists = in_array(req_addr) &&
		((req_sector == 2'd0) || (req_sector == 2'd1 && FLASH_SIZE >= 8192) ||
		(req_sector == 2'd2 && FLASH_SIZE > 8192));
	assign sector_ok = sector_exists & (full_access | (req_sector != 2'd0));

	assign do_program = req_valid & idle & (req_cmd == fsp_pkg::CMD_PROGRAM) & sector_ok & ~readout_protect_active;
	assign do_sector_erase = req_valid & idle & (req_cmd == fsp_pkg::CMD_SECTOR_ERASE) & sector_ok &
		~readout_protect_active;
	assign do_mass_erase = req_valid & idle & (req_cmd == fsp_pkg::CMD_MASS_ERASE) & full_access &
		~readout_protect_active;
	assign do_option = req_valid & idle & (req_cmd == fsp_pkg::CMD_OPTION_WRITE) & full_access;
	assign do_unprotect = do_option & readout_protect_active & req_data[fsp_pkg::OPT_PROTECT_BIT];
	assign do_read = req_valid & req_link & (req_cmd == fsp_pkg::CMD_READ);

	// ==================================================================
	// erase range of the addressed sector
	logic [IW-1:0] sec_lo;
	logic [IW-1:0] sec_hi;

	// top two sectors are 4K each
	assign sec_lo = (req_sector == 2'd0) ? (LAST_IDX - SEC_IDX + IW'(1)) :
		(req_sector == 2'd1) ? (LAST_IDX - SEC_IDX - SEC_IDX + IW'(1)) : IW'(0);
	assign sec_hi = (req_sector == 2'd0) ? LAST_IDX :
		(req_sector == 2'd1) ? (LAST_IDX - SEC_IDX) : (LAST_IDX - SEC_IDX - SEC_IDX);

	// ==================================================================
	// erase walker and option update
	logic [IW-1:0] er_idx;
	logic [IW-1:0] er_end;
	logic er_unprot;
	logic [7:0] opt_value;
	fsp_pkg::fsp_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			fsp_pkg::FSP_IDLE: begin
				if (do_sector_erase || do_mass_erase || do_unprotect) begin
					next_state = fsp_pkg::FSP_ERASE;
				end else if (do_option) begin
					next_state = fsp_pkg::FSP_OPTION;
				end
			end
			fsp_pkg::FSP_ERASE: begin
				if (er_idx == er_end) begin
					next_state = er_unprot ? fsp_pkg::FSP_OPTION : fsp_pkg::FSP_IDLE;
				end
			end
			fsp_pkg::FSP_OPTION: begin
				next_state = fsp_pkg::FSP_IDLE;
			end
			default: begin
				next_state = fsp_pkg::FSP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= fsp_pkg::FSP_IDLE;
			er_idx <= '0;
			er_end <= '0;
			er_unprot <= 1'b0;
			opt_value <= fsp_pkg::ERASED_BYTE;
		end else begin
			state <= next_state;
			if (idle) begin
				er_idx <= do_sector_erase ? sec_lo : IW'(0);
				er_end <= do_sector_erase ? sec_hi : LAST_IDX;
				er_unprot <= do_unprotect;
				opt_value <= req_data;
			end else if (state == fsp_pkg::FSP_ERASE) begin
				er_idx <= er_idx + IW'(1);
			end
		end
	end

	// ==================================================================
	// single write port into the array
	logic wr_en;
	logic [IW-1:0] wr_idx;
	logic [7:0] wr_data;

	assign wr_en = do_program | (state == fsp_pkg::FSP_ERASE) | (state == fsp_pkg::FSP_OPTION);
	assign wr_idx = (state == fsp_pkg::FSP_ERASE) ? er_idx :
		(state == fsp_pkg::FSP_OPTION) ? OPT_IDX : to_idx(req_addr);
	assign wr_data = (state == fsp_pkg::FSP_ERASE) ? fsp_pkg::ERASED_BYTE :
		(state == fsp_pkg::FSP_OPTION) ? opt_value : req_data;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// ==================================================================
	// access guard sequencer
	// two keys arm one request
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			guard_stage <= 2'd0;
		end else if (app_req && guard_armed && !link_new) begin
			guard_stage <= 2'd0;
		end else if (guard_key_valid) begin
			if (guard_key == fsp_pkg::GUARD_KEY1) begin
				guard_stage <= 2'd1;
			end else if (guard_key == fsp_pkg::GUARD_KEY2 && guard_stage == 2'd1) begin
				guard_stage <= 2'd2;
			end else begin
				guard_stage <= 2'd0;
			end
		end
	end

	// ==================================================================
	// read paths, protection flag and status outputs
	logic app_rd_in;
	logic link_rd_in;

	assign app_rd_in = in_array(app_rd_addr);
	assign link_rd_in = in_array(req_addr);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// protected until the option byte has been looked at
			readout_protect_active <= 1'b1;
			app_rdata <= 8'h00;
			link_rd_byte <= 8'h00;
			link_ack <= 1'b0;
			busy <= 1'b0;
			op_done <= 1'b0;
			op_rejected <= 1'b0;
			in_circuit_comm_mode <= 1'b0;
			app_pins_available <= 1'b1;
		end else begin
			readout_protect_active <= ~mem[OPT_IDX][fsp_pkg::OPT_PROTECT_BIT];
			app_rdata <= app_rd_in ? mem[to_idx(app_rd_addr)] : 8'h00;
			if (do_read) begin
				link_rd_byte <= (link_rd_in && !readout_protect_active) ? mem[to_idx(req_addr)] : 8'h00;
			end
			if (link_new) begin
				link_ack <= 1'b1;
			end else if (!lreq_s2) begin
				link_ack <= 1'b0;
			end
			busy <= (next_state != fsp_pkg::FSP_IDLE);
			op_done <= do_program | (state != fsp_pkg::FSP_IDLE && next_state == fsp_pkg::FSP_IDLE);
			op_rejected <= app_blocked | (req_valid & ~do_read & ~do_program & ~do_sector_erase &
				~do_mass_erase & ~do_option);
			in_circuit_comm_mode <= sel_s2;
			app_pins_available <= ~att_s2;
		end
	end

endmodule : fsp_flash_ctrl

// *** testbench/fsp_flash_ctrl_checker.sv ***
/*
 * Port-level checker for the sector-protected program memory controller.
 * Assumes it is bound to fsp_flash_ctrl and sees only its ports.
 */
`timescale 1ns/1ps

module fsp_flash_ctrl_checker #(
	parameter int FLASH_SIZE = 16384
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// application port
	input wire logic app_req,
	input wire logic [7:0] app_cmd,
	input wire logic [15:0] app_addr,
	// status
	input wire logic busy,
	input wire logic op_done,
	input wire logic op_rejected,
	input wire logic readout_protect_active,
	input wire logic in_circuit_comm_mode,
	input wire logic app_pins_available,
	// tool pins
	input wire logic tool_socket_pin,
	input wire logic tool_attached_pin,
	input wire logic link_clk,
	input wire logic prog_voltage_select_pin,
	input wire logic prog_link_data_out,
	input wire logic prog_link_data_oe_n
);
	// ==================================================================
	// helper: length of the current busy stretch
	logic [15:0] busy_cnt;

	// counts cycles while busy, clears when idle
	always_ff @(posedge clk) begin
		if (!reset_n || !busy) begin
			busy_cnt <= 16'h0000;
		end else begin
			busy_cnt <= busy_cnt + 16'h0001;
		end
	end

	// ==================================================================
	// assertions
	a_busy_length: assert property (
		@(posedge clk) disable iff (!reset_n) $fell(busy) |->
		(busy_cnt == 16'h0001 || busy_cnt == 16'h1000 || (busy_cnt >= FLASH_SIZE && busy_cnt <= FLASH_SIZE + 2)))
		else $error("erase length wrong");
	a_erase_done: assert property (
		@(posedge clk) disable iff (!reset_n) $fell(busy) |-> ##[0:1] op_done)
		else $error("no done after erase");
	a_done_excl: assert property (
		@(posedge clk) disable iff (!reset_n) !(op_done && op_rejected))
		else $error("done and rejected together");
	a_busy_refuses: assert property (
		@(posedge clk) disable iff (!reset_n) busy && app_req |=> op_rejected && !op_done)
		else $error("request taken while busy");
	a_sector0_locked: assert property (
		@(posedge clk) disable iff (!reset_n) app_req && app_cmd == fsp_pkg::CMD_PROGRAM
		&& app_addr[15:12] == 4'hF && !tool_socket_pin && !$past(tool_socket_pin, 4) |=> !op_done)
		else $error("sector zero written by application");
	a_protect_noprog: assert property (
		@(posedge clk) disable iff (!reset_n) app_req && readout_protect_active |=> !op_done)
		else $error("write accepted while protected");
	a_unprotect_erase: assert property (
		@(posedge clk) disable iff (!reset_n) $fell(readout_protect_active) && $past(reset_n, 2)
		|-> $past(busy) || $past(busy, 2))
		else $error("protection removed without erase");
	a_pins_taken: assert property (
		@(posedge clk) disable iff (!reset_n) tool_attached_pin [*5] |-> !app_pins_available)
		else $error("pins still offered to application");
	a_comm_mode: assert property (
		@(posedge clk) disable iff (!reset_n) prog_voltage_select_pin [*5] |-> in_circuit_comm_mode)
		else $error("communication mode not entered");
	a_link_idle: assert property (
		@(posedge clk) disable iff (!reset_n) !prog_voltage_select_pin |-> prog_link_data_oe_n && prog_link_data_out)
		else $error("data wire driven outside frame");
	a_protect_readout: assert property (
		@(posedge link_clk) disable iff (!prog_voltage_select_pin)
		!prog_link_data_oe_n && readout_protect_active |-> !prog_link_data_out)
		else $error("protected byte leaked");

	// ==================================================================
	// coverage of main scenarios
	c_sector_erase: cover property (@(posedge clk) $fell(busy) && busy_cnt == 16'h1000);
	c_link_drive: cover property (@(posedge link_clk) !prog_link_data_oe_n);
	c_rejected: cover property (@(posedge clk) op_rejected);
	c_protect: cover property (@(posedge clk) $rose(readout_protect_active));
endmodule : fsp_flash_ctrl_checker

bind fsp_flash_ctrl fsp_flash_ctrl_checker #(.FLASH_SIZE(FLASH_SIZE)) chk_u (
	.clk(clk), .reset_n(reset_n), .app_req(app_req), .app_cmd(app_cmd), .app_addr(app_addr),
	.busy(busy), .op_done(op_done), .op_rejected(op_rejected), .readout_protect_active(readout_protect_active),
	.in_circuit_comm_mode(in_circuit_comm_mode), .app_pins_available(app_pins_available),
	.tool_socket_pin(tool_socket_pin), .tool_attached_pin(tool_attached_pin), .link_clk(link_clk),
	.prog_voltage_select_pin(prog_voltage_select_pin), .prog_link_data_out(prog_link_data_out),
	.prog_link_data_oe_n(prog_link_data_oe_n)
);

// *** testbench/fsp_tool_model.sv ***
/*
 * Programming tool model: frames one command on the serial link.
 * Assumes the bench calls frame() and owns the device reset.
 */
`timescale 1ns/1ps

module fsp_tool_model (
	// link pins toward the device
	output logic link_clk,
	output logic prog_voltage_select_pin,
	output logic prog_link_data_in,
	// device side of the data wire
	input wire logic prog_link_data_out,
	input wire logic prog_link_data_oe_n
);
	logic drv;

	assign prog_link_data_in = prog_link_data_oe_n ? drv : prog_link_data_out;

	// idle link, clock stands still
	initial begin
		link_clk = 1'b0;
		prog_voltage_select_pin = 1'b1;
		drv = 1'b1;
		// one clean select drop clears the link logic at start
		#1;
		prog_voltage_select_pin = 1'b0;
	end

	// one framed command, clock only inside
	task automatic frame(input logic [31:0] w, input int n, input int slow, output logic [7:0] rd);
		rd = 8'h00;
		prog_voltage_select_pin = 1'b1;
		for (int i = 0; i < n; i++) begin
			if (i < 32) begin
				drv = w[31 - i];
			end else begin
				drv = ~drv; // released wire toggles
			end
			#(16 + slow);
			if (i >= 40 && i < 48) begin
				rd = {rd[6:0], prog_link_data_in};
			end
			link_clk = 1'b1;
			#16;
			link_clk = 1'b0;
		end
		#16;
		prog_voltage_select_pin = 1'b0;
		drv = ~drv;
		#60;
	endtask : frame
endmodule : fsp_tool_model

// *** testbench/flash_sector_protection_control_tb.sv ***
/*
 * Self-checking bench for the program memory controller and its link.
 * Assumes an 8K array, so sectors zero and one at E000h-FFFFh.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module flash_sector_protection_control_tb;
	localparam logic [15:0] BASE = 16'hE000;
	localparam logic [7:0] PRG = fsp_pkg::CMD_PROGRAM;
	localparam logic [7:0] SER = fsp_pkg::CMD_SECTOR_ERASE;
	localparam logic [7:0] MER = fsp_pkg::CMD_MASS_ERASE;
	localparam logic [7:0] OPT = fsp_pkg::CMD_OPTION_WRITE;
	localparam logic [7:0] K2 = fsp_pkg::GUARD_KEY2;
	logic clk, reset_n, app_req, guard_key_valid, tool_socket_pin, tool_attached_pin, s;
	logic [7:0] app_cmd, app_wdata, guard_key, app_rdata, rd, d;
	logic [15:0] app_addr, app_rd_addr, a;
	logic busy, op_done, op_rejected, readout_protect_active, in_circuit_comm_mode, app_pins_available;
	logic link_clk, prog_voltage_select_pin, prog_link_data_in, prog_link_data_out, prog_link_data_oe_n;
	logic [1:0] res;
	logic [7:0] exp_mem [0:65535];
	int num_errors = 0;
	int n_tests = 0;

	// design and tool
	fsp_flash_ctrl #(.FLASH_SIZE(8192)) dut_u (.clk(clk), .reset_n(reset_n), .app_req(app_req),
		.app_cmd(app_cmd), .app_addr(app_addr), .app_wdata(app_wdata), .guard_key_valid(guard_key_valid),
		.guard_key(guard_key), .app_rd_addr(app_rd_addr), .app_rdata(app_rdata), .busy(busy), .op_done(op_done),
		.op_rejected(op_rejected), .readout_protect_active(readout_protect_active),
		.in_circuit_comm_mode(in_circuit_comm_mode), .app_pins_available(app_pins_available),
		.tool_socket_pin(tool_socket_pin), .tool_attached_pin(tool_attached_pin), .link_clk(link_clk),
		.prog_voltage_select_pin(prog_voltage_select_pin), .prog_link_data_in(prog_link_data_in),
		.prog_link_data_out(prog_link_data_out), .prog_link_data_oe_n(prog_link_data_oe_n));
	fsp_tool_model tool_u (.link_clk(link_clk), .prog_voltage_select_pin(prog_voltage_select_pin),
		.prog_link_data_in(prog_link_data_in), .prog_link_data_out(prog_link_data_out),
		.prog_link_data_oe_n(prog_link_data_oe_n));

	// expected {done, rejected} of an unprotected application request
	function automatic logic [1:0] exp_res(input logic [7:0] c, input logic [15:0] ad, input logic sk);
		logic ok;
		ok = (ad >= BASE) && ((c == MER) ? sk : (sk || ad[15:12] != 4'hF));
		return ok ? 2'b10 : 2'b01;
	endfunction : exp_res

	// arming key pair, second key given
	task automatic keys(input logic [7:0] k);
		@(posedge clk);
		guard_key_valid <= 1'b1;
		guard_key <= fsp_pkg::GUARD_KEY1;
		@(posedge clk);
		guard_key <= k;
		@(posedge clk);
		guard_key_valid <= 1'b0;
	endtask : keys

	// one application request, waits for its answer
	task automatic req(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] wd);
		@(posedge clk);
		app_req <= 1'b1;
		app_cmd <= c;
		app_addr <= ad;
		app_wdata <= wd;
		@(posedge clk);
		app_req <= 1'b0;
		res = 2'b00;
		for (int i = 0; i < 9000 && res == 2'b00; i++) begin
			#1;
			res = {op_done, op_rejected};
			if (res == 2'b00) @(posedge clk);
		end
	endtask : req

	// compare one byte against the expected memory
	task automatic chk_rd(input logic [15:0] ad);
		@(posedge clk);
		app_rd_addr <= ad;
		repeat (2) @(posedge clk);
		#1;
		`CHK(app_rdata, (ad >= BASE) ? exp_mem[ad] : 8'h00)
	endtask : chk_rd

	// wait until the controller is idle again
	task automatic wait_idle();
		for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask : wait_idle

	// expected erase of a span
	task automatic fill_ff(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) exp_mem[i] = 8'hFF;
	endtask : fill_ff

	task automatic report_and_stop();
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// watchdog
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end

	// main sequence
	initial begin
		void'($urandom(221));
		{reset_n, app_req, guard_key_valid, tool_socket_pin, tool_attached_pin} = 5'b00000;
		{app_cmd, app_wdata, guard_key, app_addr, app_rd_addr} = 56'h0;
		fill_ff(0, 65535);
		// bench alone owns reset, never inside a frame
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(readout_protect_active, 1'b0)
		`CHK(app_pins_available, 1'b1)
		`CHK(in_circuit_comm_mode, 1'b0)
		// random programs, mode and address drawn
		for (int k = 0; k < 24; k++) begin
			a = 16'($urandom_range(32'hFFFF, 32'hD000));
			d = 8'($urandom());
			s = 1'($urandom_range(1, 0));
			@(posedge clk);
			tool_socket_pin <= s;
			keys(K2);
			req(PRG, a, d);
			`CHK(res, exp_res(PRG, a, s))
			if (res == 2'b10) exp_mem[a] = d;
			chk_rd(a);
			chk_rd(a ^ 16'h1000);
		end
		@(posedge clk);
		tool_socket_pin <= 1'b0;
		req(PRG, 16'hE010, 8'h12);
		`CHK(res, 2'b01)
		keys(8'h00);
		req(PRG, 16'hE010, 8'h12);
		`CHK(res, 2'b01)
		keys(K2);
		req(SER, 16'hF123, 8'h00);
		`CHK(res, exp_res(SER, 16'hF123, 1'b0))
		keys(K2);
		req(MER, 16'hE000, 8'h00);
		`CHK(res, exp_res(MER, 16'hE000, 1'b0))
		keys(K2);
		req(SER, 16'hE456, 8'h00);
		`CHK(res, 2'b10)
		fill_ff(16'hE000, 16'hEFFF);
		chk_rd(16'hEFFF);
		chk_rd(16'hF000);
		// link writes sector zero and reads it back slowly
		tool_u.frame({PRG, 16'hFFFE, 8'hA5}, 40, 0, rd);
		exp_mem[16'hFFFE] = 8'hA5;
		wait_idle();
		chk_rd(16'hFFFE);
		tool_u.frame({fsp_pkg::CMD_READ, 16'hFFFE, 8'h00}, 48, 20, rd);
		`CHK(rd, 8'hA5)
		// link erase of sector zero, application refused meanwhile
		tool_u.frame({SER, 16'hF000, 8'h00}, 40, 0, rd);
		keys(K2);
		req(PRG, 16'hE001, 8'h00);
		`CHK(res, 2'b01)
		wait_idle();
		fill_ff(16'hF000, 16'hFFFF);
		chk_rd(16'hFFFE);
		keys(K2);
		req(PRG, 16'hE123, 8'h3C);
		`CHK(res, 2'b10)
		exp_mem[16'hE123] = 8'h3C;
		// protect, then writes and read-out are blocked
		tool_u.frame({OPT, 16'h0000, 8'hFE}, 40, 0, rd);
		wait_idle();
		`CHK(readout_protect_active, 1'b1)
		@(posedge clk);
		tool_socket_pin <= 1'b1;
		keys(K2);
		req(PRG, 16'hE002, 8'h00);
		`CHK(res, 2'b01)
		tool_u.frame({fsp_pkg::CMD_READ, 16'hE123, 8'h00}, 48, 0, rd);
		`CHK(rd, 8'h00)
		// removing protection erases the array first
		tool_u.frame({OPT, 16'h0000, 8'hFF}, 40, 0, rd);
		wait_idle();
		`CHK(readout_protect_active, 1'b0)
		fill_ff(BASE, 16'hFFFF);
		chk_rd(16'hE123);
		keys(K2);
		req(PRG, 16'hF00F, 8'h5A);
		`CHK(res, 2'b10)
		exp_mem[16'hF00F] = 8'h5A;
		chk_rd(16'hF00F);
		keys(K2);
		req(MER, 16'hE000, 8'h00);
		`CHK(res, 2'b10)
		fill_ff(BASE, 16'hFFFF);
		chk_rd(16'hF00F);
		@(posedge clk);
		tool_attached_pin <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK(app_pins_available, 1'b0)
		report_and_stop();
	end
endmodule : flash_sector_protection_control_tb
